//--- rtl/pef_flag_bank.sv
// peripheral event flag bank with AXI4-Lite register access and one
// level interrupt output.
// assumes peripherals give one-cycle strobes synchronous to aclk.
//
// Overview of operation
// - conversion flag, bit 6, set on conversion done, sticky until cleared.
// - receive flag, bit 5, read-only: high while receive buffer full.
// - transmit flag, bit 4, read-only: high while transmit buffer empty.
// - sync serial flag, bit 3, set on transfer complete, sticky.
// - capture mode: bit 2 set on each first-timer capture, sticky.
// - compare mode: bit 2 set on compare match; unused in pwm mode.
// - period flag, bit 1, set when second timer equals its period.
// - overflow flag, bit 0, set on first-timer overflow, sticky.
// - flags set regardless of enables, so software can poll.
//
// Our own choices: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
module pef_flag_bank
  import pef_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input  wire logic                aclk,
  input  wire logic                aresetn,
  // write address channel
  input  wire logic [ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic [2:0]          s_axi_awprot,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  // write data channel
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  // write response channel
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  // read address channel
  input  wire logic [ADDR_W-1:0]   s_axi_araddr,
  input  wire logic [2:0]          s_axi_arprot,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  // read data channel
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // peripheral events
  input  wire pef_events_type      events,
  input  wire logic                rx_load,
  input  wire logic [7:0]          rx_data,
  input  wire logic                tx_take,
  // transmit side to serial unit
  output logic [7:0]               tx_data,
  output logic                     tx_valid,
  // interrupt
  output logic                     irq
);

  // refuse address widths that the word decode below cannot serve: the
  // offsets need eight bits, and the bus carries no more than 32
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr_w
    $error("pef_flag_bank: ADDR_W must be 8..32");
  end

  // register offset match, used by read and write decode; the two low
  // address bits are ignored, so a byte address inside a word still hits.
  // the upper bits are tested by a shift, which stays legal even at the
  // narrowest address width, where no upper bits exist at all
  function automatic logic is_reg(input logic [ADDR_W-1:0] a,
                                  input logic [7:0]        ofs);
    is_reg = (a[7:2] == ofs[7:2]) && ((a >> 8) == '0);
  endfunction : is_reg

  // write channel capture
  logic [ADDR_W-1:0] aw_addr_q;
  logic              aw_have_q;
  logic [31:0]       w_data_q;
  logic [3:0]        w_strb_q;
  logic              w_have_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              wr_fire;

  // each channel is refused while its word is held or a response waits,
  // so a second write cannot slip in ahead of the first one's answer
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready  = !w_have_q && !bvalid_q;
  assign wr_fire       = aw_have_q && w_have_q && !bvalid_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;

  // hold address and data until both present; they may arrive in either
  // order, and both are consumed together by the write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q  <= 1'b0;
      aw_addr_q <= '0;
      w_data_q  <= '0;
      w_strb_q  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // write decode; only the low byte lane carries register bits
  // a mapped but read-only offset still answers okay and changes nothing
  logic wr_flags;
  logic wr_enable;
  logic wr_clear;
  logic wr_mode;
  logic wr_txbuf;
  logic wr_hit;
  logic lane0;

  always_comb begin
    lane0     = w_strb_q[0];
    wr_flags  = 1'b0;
    wr_enable = 1'b0;
    wr_clear  = 1'b0;
    wr_mode   = 1'b0;
    wr_txbuf  = 1'b0;
    wr_hit    = 1'b1;
    if (is_reg(aw_addr_q, PEF_OFS_FLAGS)) begin
      wr_flags = wr_fire && lane0;
    end else if (is_reg(aw_addr_q, PEF_OFS_ENABLE)) begin
      wr_enable = wr_fire && lane0;
    end else if (is_reg(aw_addr_q, PEF_OFS_CLEAR)) begin
      wr_clear = wr_fire && lane0;
    end else if (is_reg(aw_addr_q, PEF_OFS_MODE)) begin
      wr_mode = wr_fire && lane0;
    end else if (is_reg(aw_addr_q, PEF_OFS_TXBUF)) begin
      wr_txbuf = wr_fire && lane0;
    end else if (is_reg(aw_addr_q, PEF_OFS_RXBUF)) begin
      wr_hit = 1'b1;                       // read-only, write ignored
    end else begin
      wr_hit = 1'b0;
    end
  end

  // write response; unmapped offsets answer with an error
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= PEF_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wr_hit ? PEF_RESP_OKAY : PEF_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // read channel: a read is taken whenever no answer waits, and its data
  // is registered so the answer stands unchanged until it is taken
  logic        rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0]  rresp_q;
  logic        rd_fire;
  logic        rd_rxbuf;

  assign s_axi_arready = !rvalid_q;
  assign rd_fire       = s_axi_arvalid && !rvalid_q;
  assign rd_rxbuf      = rd_fire && is_reg(s_axi_araddr, PEF_OFS_RXBUF);
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // control registers
  logic [7:0]       enable_q;
  pef_ccp_mode_type mode_q;

  // buffer-state bits are forced on by any enable write that strobes the low byte lane, so that a full
  // receive or an empty transmit buffer can raise the interrupt
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_q <= PEF_ENA_RST;
    end else if (wr_enable) begin
      enable_q <= w_data_q[7:0] & PEF_WR_MASK | 8'h30;
    end
  end

  // mode selects which capture/compare strobe may set its flag
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= PEF_CCP_OFF;
    end else if (wr_mode) begin
      mode_q <= pef_ccp_mode_type'(w_data_q[1:0]);
    end
  end

  // receive holding buffer: full until software reads it
  // a load in the cycle of a read keeps the buffer full, so no byte is
  // lost; software then sees the flag stay up and reads again
  logic [7:0] rx_buf_q;
  logic       rx_full_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_buf_q  <= PEF_BUF_RST;
      rx_full_q <= 1'b0;
    end else if (rx_load) begin
      rx_buf_q  <= rx_data;                // new byte wins over a read
      rx_full_q <= 1'b1;
    end else if (rd_rxbuf) begin
      rx_full_q <= 1'b0;
    end
  end

  // transmit holding buffer: empty until software writes it
  // a write in the cycle of a drain keeps the buffer full with the new byte
  logic [7:0] tx_buf_q;
  logic       tx_full_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_buf_q  <= PEF_BUF_RST;
      tx_full_q <= 1'b0;
    end else if (wr_txbuf) begin
      tx_buf_q  <= w_data_q[7:0];
      tx_full_q <= 1'b1;
    end else if (tx_take) begin
      tx_full_q <= 1'b0;                   // serial unit drained it
    end
  end

  assign tx_data  = tx_buf_q;
  assign tx_valid = tx_full_q;

  // sticky flags
  logic       ccp_event;
  logic [7:0] set_vec;
  logic [7:0] sticky_q;
  logic [7:0] flags;

  pef_ccp_gate u_ccp (
    .mode      (mode_q),
    .capture   (events.capture),
    .compare   (events.compare),
    .event_out (ccp_event)
  );

  // hardware set per bit, independent of enables
  always_comb begin
    set_vec              = 8'h00;
    set_vec[PEF_BIT_ADC] = events.conv_done;
    set_vec[PEF_BIT_SSP] = events.sync_done;
    set_vec[PEF_BIT_CCP] = ccp_event;
    set_vec[PEF_BIT_PER] = events.period_match;
    set_vec[PEF_BIT_OVF] = events.overflow;
  end

  // only writable bits get a flip-flop; the others are constant zero
  genvar gi;
  generate
    for (gi = 0; gi < PEF_FLAG_W; gi++) begin : g_flag
      if (PEF_WR_MASK[gi]) begin : g_sticky
        pef_sticky_bit u_bit (
          .aclk    (aclk),
          .aresetn (aresetn),
          .set     (set_vec[gi]),
          .wr_en   (wr_flags),
          .wr_val  (w_data_q[gi]),
          .clr     (wr_clear && w_data_q[gi]),
          .flag_q  (sticky_q[gi])
        );
      end else begin : g_none
        assign sticky_q[gi] = 1'b0;
      end
    end
  endgenerate

  // live view: buffer flags follow buffer state, bit 7 zero
  // buffer flags are never stored, so writes cannot touch them and they
  // clear on their own when the buffer changes state
  always_comb begin
    flags             = sticky_q;
    flags[7]          = 1'b0;
    flags[PEF_BIT_RX] = rx_full_q;
    flags[PEF_BIT_TX] = !tx_full_q;
  end

  // read data and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0000_0000;
      rresp_q  <= PEF_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rresp_q  <= PEF_RESP_OKAY;
      if (is_reg(s_axi_araddr, PEF_OFS_FLAGS)) begin
        rdata_q <= {24'h00_0000, flags};
      end else if (is_reg(s_axi_araddr, PEF_OFS_ENABLE)) begin
        rdata_q <= {24'h00_0000, enable_q};
      end else if (is_reg(s_axi_araddr, PEF_OFS_CLEAR)) begin
        rdata_q <= 32'h0000_0000;          // write-only
      end else if (is_reg(s_axi_araddr, PEF_OFS_MODE)) begin
        rdata_q <= {30'h0000_0000, mode_q};
      end else if (is_reg(s_axi_araddr, PEF_OFS_RXBUF)) begin
        rdata_q <= {24'h00_0000, rx_buf_q};
      end else if (is_reg(s_axi_araddr, PEF_OFS_TXBUF)) begin
        rdata_q <= {24'h00_0000, tx_buf_q};
      end else begin
        rdata_q <= 32'h0000_0000;
        rresp_q <= PEF_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // level interrupt while any enabled flag is set
  // registered so the pin is free of glitches; it trails the flags a cycle
  logic irq_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(flags & enable_q);
    end
  end

  assign irq = irq_q;

endmodule : pef_flag_bank

//--- shared/pef_pkg.sv
// package for the peripheral event flag bank: register map, bit positions,
// reset values and the bus-side carrier types.
// assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
package pef_pkg;

  // register byte offsets
  localparam logic [7:0] PEF_OFS_FLAGS  = 8'h00; // event flags, mixed access
  localparam logic [7:0] PEF_OFS_ENABLE = 8'h04; // interrupt enable
  localparam logic [7:0] PEF_OFS_CLEAR  = 8'h08; // write-one-to-clear
  localparam logic [7:0] PEF_OFS_MODE   = 8'h0C; // capture/compare mode
  localparam logic [7:0] PEF_OFS_RXBUF  = 8'h10; // serial receive buffer
  localparam logic [7:0] PEF_OFS_TXBUF  = 8'h14; // serial transmit buffer

  // flag bit positions
  localparam int PEF_BIT_OVF  = 0; // timer overflow
  localparam int PEF_BIT_PER  = 1; // period match
  localparam int PEF_BIT_CCP  = 2; // capture/compare
  localparam int PEF_BIT_SSP  = 3; // sync serial done
  localparam int PEF_BIT_TX   = 4; // transmit buffer empty
  localparam int PEF_BIT_RX   = 5; // receive buffer full
  localparam int PEF_BIT_ADC  = 6; // conversion done
  localparam int PEF_FLAG_W   = 8;

  // bits software may write directly (6,3,2,1,0)
  localparam logic [7:0] PEF_WR_MASK   = 8'h4F;
  localparam logic [7:0] PEF_FLAG_RST  = 8'h00;
  localparam logic [7:0] PEF_ENA_RST   = 8'h00;
  localparam logic [7:0] PEF_BUF_RST   = 8'h00;

  // AXI response codes
  localparam logic [1:0] PEF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] PEF_RESP_SLVERR = 2'h2;

  // capture/compare unit mode
  typedef enum logic [1:0] {
    PEF_CCP_OFF     = 2'b00,
    PEF_CCP_CAPTURE = 2'b01,
    PEF_CCP_COMPARE = 2'b10,
    PEF_CCP_PWM     = 2'b11
  } pef_ccp_mode_type;

  // peripheral event strobes, one-cycle pulses
  typedef struct packed {
    logic conv_done;
    logic sync_done;
    logic capture;
    logic compare;
    logic period_match;
    logic overflow;
  } pef_events_type;

  // one decoded register access
  typedef struct packed {
    logic       hit;
    logic [7:0] ofs;
  } pef_access_type;

endpackage : pef_pkg

//--- rtl/pef_ccp_gate.sv
// capture/compare event qualifier: passes only the strobe of the active mode.
// assumes strobes are one-cycle pulses synchronous to aclk.
`timescale 1ns/1ps
module pef_ccp_gate
  import pef_pkg::*;
(
  // mode and raw strobes
  input  wire pef_ccp_mode_type mode,
  input  wire logic             capture,
  input  wire logic             compare,
  // qualified event
  output logic                  event_out
);

  // pwm and off ignore both strobes
  always_comb begin
    case (mode)
      PEF_CCP_CAPTURE: event_out = capture;
      PEF_CCP_COMPARE: event_out = compare;
      default:         event_out = 1'b0;
    endcase
  end

endmodule : pef_ccp_gate

//--- rtl/pef_sticky_bit.sv
// one sticky flag: hardware set, software write and clear, set wins.
// assumes all inputs synchronous to aclk.
`timescale 1ns/1ps
module pef_sticky_bit
  import pef_pkg::*;
(
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // controls
  input  wire logic set,
  input  wire logic wr_en,
  input  wire logic wr_val,
  input  wire logic clr,
  // state
  output logic      flag_q
);

  // set overrides any write or clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end else if (wr_en) begin
      flag_q <= wr_val;
    end
  end

endmodule : pef_sticky_bit

//--- verification/pef_flag_bank_assertions.sv
// checker for the flag bank register bus and transmit handshake.
// assumes it is bound to pef_flag_bank and sees only its ports.
`timescale 1ns/1ps
module pef_flag_bank_assertions
  import pef_pkg::*;
(
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // register bus
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // transmit side
  input wire logic        tx_valid,
  input wire logic        tx_take
);
  // one domain, checks off in reset
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // answers stand until taken
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  chk_b_release: assert property (s_axi_bvalid && s_axi_bready
    |=> !s_axi_bvalid) else $error("bvalid stuck");
  // one transfer of each kind at a time
  chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("arready during rvalid");
  chk_aw_block: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready) else $error("aw/w ready in bvalid");
  // answer timing
  chk_r_answer: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read answer late");
  chk_b_cause: assert property ($rose(s_axi_bvalid)
    |-> $past(s_axi_awready) == 1'b0 && $past(s_axi_wready) == 1'b0)
    else $error("bvalid without address and data");
  // read data contents
  chk_err_data: assert property (s_axi_rvalid &&
    s_axi_rresp == PEF_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read with data");
  chk_upper_zero: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:8] == 24'h0) else $error("upper bits set");
  // drained buffer goes empty unless refilled
  chk_tx_drain: assert property (tx_valid && tx_take
    |=> !tx_valid || $rose(s_axi_bvalid)) else $error("tx not drained");
endmodule : pef_flag_bank_assertions

bind pef_flag_bank pef_flag_bank_assertions pef_flag_bank_assertions_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .tx_valid(tx_valid), .tx_take(tx_take));

//--- verification/pef_periph_model.sv
// model of the peripherals: event strobes, receive loads, transmit drain.
// assumes callers enter its tasks right after a rising aclk edge.
`timescale 1ns/1ps
module pef_periph_model
  import pef_pkg::*;
(
  // clock
  input  wire logic       aclk,
  // transmit side
  input  wire logic       tx_valid,
  input  wire logic [7:0] stall,
  output logic            tx_take,
  // events and receive side
  output pef_events_type  events,
  output logic            rx_load,
  output logic [7:0]      rx_data
);
  int cnt = 0;

  // quiet event and receive outputs from time zero
  initial begin
    events = '0;
    rx_load = 1'b0;
    rx_data = 8'h00;
  end

  // one-cycle event strobe
  task automatic fire(input pef_events_type e);
    @(posedge aclk);
    events <= e;
    @(posedge aclk);
    events <= '0;
  endtask : fire

  // receive load; data is not held after the strobe
  task automatic load(input logic [7:0] d);
    @(posedge aclk);
    rx_data <= d;
    rx_load <= 1'b1;
    @(posedge aclk);
    rx_data <= ~d;
    rx_load <= 1'b0;
  endtask : load

  // drain the transmit buffer after a stall of some cycles
  always @(posedge aclk) begin
    tx_take <= 1'b0;
    if (tx_valid && !tx_take) begin
      if (cnt >= stall) begin
        tx_take <= 1'b1;
        cnt <= 0;
      end else begin
        cnt <= cnt + 1;
      end
    end
  end
endmodule : pef_periph_model

//--- verification/pef_flag_bank_tb.sv
// self-checking bench for the flag bank over its register bus.
// assumes the peripheral model and the bound checker.
`timescale 1ns/1ps
module pef_flag_bank_tb
  import pef_pkg::*;
;
  localparam logic [5:0] EVS [4] = '{6'h20, 6'h10, 6'h02, 6'h01};
  localparam logic [7:0] BITS [4] = '{8'h40, 8'h08, 8'h02, 8'h01};
  logic aclk, aresetn, aw_v, w_v, b_r, ar_v, r_r;
  logic aw_r, w_r, b_v, ar_r, r_v, irq, tx_v, tx_t, rx_l;
  logic [7:0] aw_a, ar_a, stall, rx_d, tx_d;
  logic [31:0] w_d, r_d;
  logic [1:0] b_s, r_s;
  pef_events_type ev;
  logic [33:0] q[$];
  int n_errors = 0;
  int total_checks = 0;

  pef_flag_bank pef_flag_bank_inst (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(aw_a),
    .s_axi_awprot(3'h0), .s_axi_awvalid(aw_v), .s_axi_awready(aw_r),
    .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
    .s_axi_wready(w_r), .s_axi_bresp(b_s), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arprot(3'h0),
    .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d),
    .s_axi_rresp(r_s), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .events(ev), .rx_load(rx_l), .rx_data(rx_d), .tx_take(tx_t),
    .tx_data(tx_d), .tx_valid(tx_v), .irq(irq));
  pef_periph_model pef_periph_model_inst (
    .aclk(aclk), .tx_valid(tx_v), .stall(stall), .tx_take(tx_t),
    .events(ev), .rx_load(rx_l), .rx_data(rx_d));

  task automatic cmp(logic [33:0] got, logic [33:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic stop_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic tmo(int n);
    if (n >= 200) begin
      n_errors++;
      stop_test();
    end
  endtask : tmo

  // compare each bus answer with the oldest note
  always @(posedge aclk) begin
    if (b_v && b_r) cmp({b_s, 32'h0}, q.pop_front());
    if (r_v && r_r) cmp({r_s, r_d}, q.pop_front());
  end

  task automatic wr(logic [7:0] a, logic [31:0] d,
                    logic [1:0] r = PEF_RESP_OKAY);
    int n = 0;
    q.push_back({r, 32'h0});
    @(posedge aclk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'b1;
    w_v <= 1'b1;
    b_r <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (aw_r) aw_v <= 1'b0;
      if (w_r) w_v <= 1'b0;
    end while (!b_v && n < 200);
    b_r <= 1'b0;
    tmo(n);
  endtask : wr

  task automatic rd(logic [7:0] a, logic [31:0] d,
                    logic [1:0] r = PEF_RESP_OKAY);
    int n = 0;
    q.push_back({r, d});
    @(posedge aclk);
    ar_a <= a;
    ar_v <= 1'b1;
    r_r <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (ar_r) ar_v <= 1'b0;
    end while (!r_v && n < 200);
    r_r <= 1'b0;
    tmo(n);
  endtask : rd

  task automatic fire(logic [5:0] e);
    pef_periph_model_inst.fire(e);
  endtask : fire

  task automatic lvl(logic e);
    repeat (2) @(posedge aclk);
    cmp({33'h0, irq}, {33'h0, e});
  endtask : lvl

  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // main sequence
  initial begin
    logic [31:0] d;
    int n;
    {aw_v, w_v, b_r, ar_v, r_r} = '0;
    {aw_a, ar_a, stall, w_d} = '0;
    aresetn = 1'b0;
    d = $urandom(32'h217daa1d);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(PEF_OFS_FLAGS, 32'h10);
    rd(PEF_OFS_ENABLE, 32'h0);
    for (int i = 0; i < 4; i++) begin
      fire(EVS[i]);
      rd(PEF_OFS_FLAGS, {24'h0, BITS[i] | 8'h10});
      rd(PEF_OFS_FLAGS, {24'h0, BITS[i] | 8'h10});
      wr(PEF_OFS_CLEAR, {24'h0, BITS[i]});
      rd(PEF_OFS_FLAGS, 32'h10);
    end
    for (int m = 0; m < 4; m++) begin
      wr(PEF_OFS_MODE, m);
      fire(6'h08);
      rd(PEF_OFS_FLAGS, m == 1 ? 32'h14 : 32'h10);
      fire(6'h04);
      rd(PEF_OFS_FLAGS, m == 1 || m == 2 ? 32'h14 : 32'h10);
      wr(PEF_OFS_CLEAR, 32'h04);
    end
    repeat (4) begin
      d = $urandom | 32'h80;
      wr(PEF_OFS_FLAGS, d);
      rd(PEF_OFS_FLAGS, {24'h0, d[7:0] & PEF_WR_MASK | 8'h10});
    end
    wr(PEF_OFS_FLAGS, 32'h0);
    d = $urandom;
    pef_periph_model_inst.load(d[7:0]);
    wr(PEF_OFS_FLAGS, 32'h0);
    rd(PEF_OFS_FLAGS, 32'h30);
    rd(PEF_OFS_RXBUF, {24'h0, d[7:0]});
    // the receive buffer ignores writes
    wr(PEF_OFS_RXBUF, ~d);
    rd(PEF_OFS_RXBUF, {24'h0, d[7:0]});
    rd(PEF_OFS_FLAGS, 32'h10);
    // interrupt raised, masked by a full buffer, cleared
    wr(PEF_OFS_ENABLE, 32'h01);
    lvl(1'b1);
    rd(PEF_OFS_ENABLE, 32'h31);
    stall <= 8'h50;
    wr(PEF_OFS_TXBUF, 32'h3C);
    cmp({25'h0, tx_v, tx_d}, {25'h0, 1'b1, 8'h3C});
    lvl(1'b0);
    rd(PEF_OFS_FLAGS, 32'h00);
    fire(6'h01);
    lvl(1'b1);
    wr(PEF_OFS_CLEAR, 32'h01);
    lvl(1'b0);
    n = 0;
    while (tx_v && n < 300) begin
      @(posedge aclk);
      n++;
    end
    tmo(n > 299 ? 200 : 0);
    rd(PEF_OFS_FLAGS, 32'h10);
    // overflow strobe lands on the same edge as its clear: the set wins
    fork
      wr(PEF_OFS_CLEAR, 32'h01);
      begin
        @(posedge aclk);
        fire(6'h01);
      end
    join
    rd(PEF_OFS_FLAGS, 32'h11);
    wr(PEF_OFS_CLEAR, 32'h01);
    rd(PEF_OFS_FLAGS, 32'h10);
    rd(PEF_OFS_CLEAR, 32'h0);
    rd(8'h40, 32'h0, PEF_RESP_SLVERR);
    wr(8'h40, 32'hFF, PEF_RESP_SLVERR);
    rd(PEF_OFS_FLAGS, 32'h10);
    stop_test();
  end
endmodule : pef_flag_bank_tb
